// [verilog/css_pkg.sv]
package css_pkg;
	// register offsets on the plain register port
	localparam logic [1:0] OFS_OSC_CTRL = 2'h0;
	localparam logic [1:0] OFS_SEC_TMR = 2'h1;
	localparam logic [1:0] OFS_OSC_TRIM = 2'h2;
	// oscillator_control field positions
	localparam int BIT_IDLE = 7;
	localparam int IRCF_HI = 6;
	localparam int IRCF_LO = 4;
	localparam int BIT_PRI_DONE = 3;
	localparam int BIT_INT_STABLE = 2;
	// secondary_timer_control field positions
	localparam int BIT_SEC_ACTIVE = 6;
	localparam int BIT_SEC_EN = 3;
	// oscillator_trim field positions
	localparam int BIT_LF_SRC = 7;
	localparam int TRIM_HI = 4;
	// source select encodings and mux source indices
	localparam logic [1:0] SCS_PRIMARY = 2'h0;
	localparam logic [1:0] SCS_SECONDARY = 2'h1;
	localparam logic [1:0] SRC_INTERNAL = 2'h2;
	// internal block frequency codes
	localparam logic [2:0] IRCF_LOWFREQ = 3'h0;
	localparam logic [2:0] IRCF_DIRECT = 3'h7;
	// values after reset
	localparam logic [1:0] RST_SCS = 2'h0;
	localparam logic [2:0] RST_IRCF = 3'h4;
	// cycle counts
	localparam int OST_CYCLES = 1024;
	localparam int SETTLE_EDGES = 64;
	localparam logic [1:0] OLD_EDGES = 2'h2;
	localparam logic [1:0] NEW_EDGES = 2'h3;
	// clock switch states
	typedef enum logic [2:0] {
		MUX_RUN = 3'b001,
		MUX_DRAIN = 3'b010,
		MUX_WAIT = 3'b100
	} css_mux_state_t;
endpackage : css_pkg

// [verilog/css_clk_if.sv]
`timescale 1ns/10ps
interface css_clk_if;
	logic [3:0] srcLvl;
	logic [1:0] reqSel;
	logic [1:0] curSel;
	logic busy;
	logic clkOut;
	modport mux (input srcLvl, input reqSel, output curSel, output busy,
		output clkOut);
	modport ctl (output srcLvl, output reqSel, input curSel, input busy,
		input clkOut);
endinterface : css_clk_if

// [verilog/css_postscaler.sv]
`timescale 1ns/10ps
module css_postscaler import css_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic mainLvl,
	input wire logic lpLvl,
	input wire logic [2:0] freqSel,
	input wire logic lfFromMain,
	output logic clkOut
);
	logic prevMain_q;
	logic [7:0] divCnt_q;
	logic [7:0] divCnt_d;
	logic mainRise;
	logic tap;
	logic out_q;

	// divider advances on each rising edge of the main oscillator
	assign mainRise = mainLvl & ~prevMain_q;
	assign divCnt_d = mainRise ? divCnt_q + 8'h01 : divCnt_q;

	// tap select; a code change takes effect on the next cycle
	assign tap = (freqSel == IRCF_DIRECT) ? mainLvl :
		(freqSel == 3'h6) ? divCnt_q[0] :
		(freqSel == 3'h5) ? divCnt_q[1] :
		(freqSel == 3'h4) ? divCnt_q[2] :
		(freqSel == 3'h3) ? divCnt_q[3] :
		(freqSel == 3'h2) ? divCnt_q[4] :
		(freqSel == 3'h1) ? divCnt_q[5] :
		lfFromMain ? divCnt_q[7] : lpLvl;

	// registered so the mux never sees a decode glitch
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			prevMain_q <= 1'b0;
			divCnt_q <= 8'h00;
			out_q <= 1'b0;
		end else begin
			prevMain_q <= mainLvl;
			divCnt_q <= divCnt_d;
			out_q <= tap;
		end
	end

	assign clkOut = out_q;
endmodule : css_postscaler

// [verilog/css_clk_mux.sv]
`timescale 1ns/10ps
module css_clk_mux import css_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_b,
	css_clk_if.mux mx
);
	css_mux_state_t st_q, st_d;
	logic [3:0] prevLvl_q;
	logic [1:0] cur_q, cur_d;
	logic [1:0] tgt_q, tgt_d;
	logic [1:0] cnt_q, cnt_d;
	logic out_q, out_d;
	logic oldLvl, newLvl, oldFall, newRise;

	// edges seen per source; the request is tracked against both
	assign oldLvl = mx.srcLvl[cur_q];
	assign newLvl = mx.srcLvl[tgt_q];
	assign oldFall = prevLvl_q[cur_q] & ~oldLvl;
	assign newRise = ~prevLvl_q[tgt_q] & newLvl;

	// old clock is parked low before the new one is let through
	always_comb begin
		st_d = st_q;
		cur_d = cur_q;
		tgt_d = tgt_q;
		cnt_d = cnt_q;
		out_d = 1'b0;
		case (st_q)
		MUX_RUN: begin
			out_d = oldLvl;
			if (mx.reqSel != cur_q) begin
				st_d = MUX_DRAIN;
				tgt_d = mx.reqSel;
				cnt_d = 2'h0;
			end
		end
		MUX_DRAIN: begin
			// follow old only until its first fall, then hold low
			out_d = (cnt_q == 2'h0) ? oldLvl : 1'b0;
			if (oldFall) begin
				cnt_d = cnt_q + 2'h1;
				if (cnt_q == OLD_EDGES - 2'h1) begin
					st_d = MUX_WAIT;
					cnt_d = 2'h0;
				end
			end
		end
		MUX_WAIT: begin
			if (newRise && cnt_q != NEW_EDGES)
				cnt_d = cnt_q + 2'h1;
			// resume only on a low new level: no cut high pulse
			if (cnt_q == NEW_EDGES && !newLvl) begin
				st_d = MUX_RUN;
				cur_d = tgt_q;
			end
		end
		default: begin
			st_d = MUX_RUN;
		end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= MUX_RUN;
			prevLvl_q <= 4'h0;
			cur_q <= SCS_PRIMARY;
			tgt_q <= SCS_PRIMARY;
			cnt_q <= 2'h0;
			out_q <= 1'b0;
		end else begin
			st_q <= st_d;
			prevLvl_q <= mx.srcLvl;
			cur_q <= cur_d;
			tgt_q <= tgt_d;
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign mx.curSel = cur_q;
	assign mx.busy = (st_q != MUX_RUN);
	assign mx.clkOut = out_q;
endmodule : css_clk_mux

// [verilog/css_clock_switch.sv]
// Summary of operation
// - source select 00 primary, 01 secondary crystal, 1x internal block.
// - a change of source select switches the clock after a short pause.
// - every reset clears source select to primary.
// - frequency select 111 gives 8 MHz down to 125 kHz at 001, 000 low.
// - frequency select resets to 100, a 1 MHz internal output.
// - frequency select changes take effect at once on the internal clock.
// - at 000 the low source is main osc divided by 256 or the RC osc.
// - the low-power RC osc always clocks the watchdog.
// - primary done reads 1 after start-up timer expiry on primary clock.
// - internal stable reads 1 once main osc settled and clocking device.
// - secondary active is set while the crystal oscillator clocks device.
// - at most one of the three status flags is set at once.
// - sleep instruction enters Idle if idle bit set, else Sleep.
// - selecting secondary while its oscillator is disabled is ignored.
// - switch pauses for two old-source falling edges plus three new rising edges.
// - reset value of primary done follows the two-speed start-up strap.
// - secondary oscillator keeps running in power-managed modes.
`timescale 1ns/10ps
module css_clock_switch import css_pkg::*; #(
	parameter int OST_COUNT = OST_CYCLES,
	parameter int SETTLE_COUNT = SETTLE_EDGES
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	input wire logic twoSpeedStartupCfg,
	input wire logic priOscLvl,
	input wire logic secOscLvl,
	input wire logic mainIntOscLvl,
	input wire logic lpRcOscLvl,
	input wire logic sleepExec,
	input wire logic wakeEvent,
	output logic sysClk,
	output logic priOscEn,
	output logic secOscEn,
	output logic mainIntOscEn,
	output logic lpRcOscEn,
	output logic [4:0] mainOscTrim,
	output logic wdtClk,
	output logic idleMode,
	output logic sleepMode,
	output logic switchBusy
);
	localparam int OST_W = $clog2(OST_COUNT + 1);
	localparam int SET_W = $clog2(SETTLE_COUNT + 1);

	// software-visible control state
	logic idle_q;
	logic [2:0] ircf_q;
	logic [1:0] scs_q;
	logic secEn_q;
	logic lfSrc_q;
	logic [4:0] trim_q;
	// start-up and settle tracking
	logic started_q;
	logic ostDone_q;
	logic [OST_W-1:0] ostCnt_q;
	logic settled_q;
	logic [SET_W-1:0] setCnt_q;
	logic prevPri_q;
	logic prevMain_q;
	// power mode flops
	logic idleMode_q;
	logic sleepMode_q;
	// output flops: every top-level output not driven by a control or power mode flop leaves from one of these
	logic priOscEn_q;
	logic mainOscEn_q;
	logic lpRcEn_q;
	logic sysClk_q;
	logic wdtClk_q;
	logic busy_q;
	logic [7:0] rdData_q;

	// register port decode
	logic wrCtrl;
	logic wrSec;
	logic wrTrim;
	logic secBlocked;
	// source selection and oscillator edges
	logic [1:0] selSrc;
	logic useLpRc;
	logic priRise;
	logic mainRise;
	// status flags and next enables
	logic priDone;
	logic intStable;
	logic secActive;
	logic priOscEn_d;
	logic mainOscEn_d;
	logic psClk;
	// read data
	logic [7:0] ctrlRd;
	logic [7:0] secRd;
	logic [7:0] trimRd;
	logic [7:0] rdData_d;

	css_clk_if clkBus();

	// write decode
	assign wrCtrl = regWrEn && (regAddr == OFS_OSC_CTRL);
	assign wrSec = regWrEn && (regAddr == OFS_SEC_TMR);
	assign wrTrim = regWrEn && (regAddr == OFS_OSC_TRIM);
	// a secondary request with its oscillator off leaves select alone
	assign secBlocked = (regWrData[1:0] == SCS_SECONDARY) && !secEn_q;

	// either 1x code maps to the internal block source
	assign selSrc = scs_q[1] ? SRC_INTERNAL : scs_q;
	assign useLpRc = (ircf_q == IRCF_LOWFREQ) && !lfSrc_q;
	assign priRise = priOscLvl & ~prevPri_q;
	assign mainRise = mainIntOscLvl & ~prevMain_q;

	// status flags are qualified by the running source and an idle
	// mux, so at most one can read set at any time
	assign priDone = ostDone_q && (clkBus.curSel == SCS_PRIMARY) &&
		!clkBus.busy;
	assign intStable = settled_q && !useLpRc &&
		(clkBus.curSel == SRC_INTERNAL) && !clkBus.busy;
	assign secActive = (clkBus.curSel == SCS_SECONDARY) &&
		!clkBus.busy;

	// old source stays on through the drain, so the switch can finish;
	// primary is stopped in every power-managed mode but its own
	assign priOscEn_d = !sleepMode_q &&
		(selSrc == SCS_PRIMARY || clkBus.curSel == SCS_PRIMARY);
	// main osc off when the RC osc serves the low-frequency code
	assign mainOscEn_d = !sleepMode_q && !useLpRc &&
		(selSrc == SRC_INTERNAL || clkBus.curSel == SRC_INTERNAL);

	// clock sources into the glitch-free mux
	assign clkBus.srcLvl = {1'b0, psClk, secOscLvl, priOscLvl};
	assign clkBus.reqSel = selSrc;

	css_postscaler u_post (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.mainLvl(mainIntOscLvl),
		.lpLvl(lpRcOscLvl),
		.freqSel(ircf_q),
		.lfFromMain(lfSrc_q),
		.clkOut(psClk)
	);

	css_clk_mux u_mux (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.mx(clkBus.mux)
	);

	// read data assembly and decode
	assign ctrlRd = {idle_q, ircf_q, priDone, intStable, scs_q};
	assign secRd = {1'b0, secActive, 2'h0, secEn_q, 3'h0};
	assign trimRd = {lfSrc_q, 2'h0, trim_q};
	assign rdData_d = !regRdEn ? 8'h00 :
		(regAddr == OFS_OSC_CTRL) ? ctrlRd :
		(regAddr == OFS_SEC_TMR) ? secRd :
		(regAddr == OFS_OSC_TRIM) ? trimRd : 8'h00;

	// control register: a blocked secondary request keeps the old
	// select, but the other fields of the write still land
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			idle_q <= 1'b0;
			ircf_q <= RST_IRCF;
			scs_q <= RST_SCS;
		end else if (wrCtrl) begin
			idle_q <= regWrData[BIT_IDLE];
			ircf_q <= regWrData[IRCF_HI:IRCF_LO];
			if (!secBlocked)
				scs_q <= regWrData[1:0];
		end
	end

	// secondary oscillator enable bit
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			secEn_q <= 1'b0;
		else if (wrSec)
			secEn_q <= regWrData[BIT_SEC_EN];
	end

	// low-frequency source and trim; the trim leaves only as a pin and as read data
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			lfSrc_q <= 1'b0;
			trim_q <= 5'h00;
		end else if (wrTrim) begin
			lfSrc_q <= regWrData[BIT_LF_SRC];
			trim_q <= regWrData[TRIM_HI:0];
		end
	end

	// start-up timer; the strap is caught on the first edge after
	// release, since an async reset may load only constants
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			started_q <= 1'b0;
			ostDone_q <= 1'b0;
			ostCnt_q <= '0;
			prevPri_q <= 1'b0;
		end else begin
			prevPri_q <= priOscLvl;
			if (!started_q) begin
				started_q <= 1'b1;
				ostDone_q <= !twoSpeedStartupCfg;
			end else if (!priOscEn_q) begin
				ostDone_q <= 1'b0;
				ostCnt_q <= '0;
			end else if (priRise && !ostDone_q) begin
				ostCnt_q <= ostCnt_q + OST_W'(1);
				if (ostCnt_q == OST_W'(OST_COUNT - 1))
					ostDone_q <= 1'b1;
			end
		end
	end

	// main internal osc settle counter, restarted whenever it is off
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			settled_q <= 1'b0;
			setCnt_q <= '0;
			prevMain_q <= 1'b0;
		end else begin
			prevMain_q <= mainIntOscLvl;
			if (!mainOscEn_q) begin
				settled_q <= 1'b0;
				setCnt_q <= '0;
			end else if (mainRise && !settled_q) begin
				setCnt_q <= setCnt_q + SET_W'(1);
				if (setCnt_q == SET_W'(SETTLE_COUNT - 1))
					settled_q <= 1'b1;
			end
		end
	end

	// power mode: a sleep instruction beats a wake in the same cycle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			idleMode_q <= 1'b0;
			sleepMode_q <= 1'b0;
		end else if (sleepExec) begin
			idleMode_q <= idle_q;
			sleepMode_q <= !idle_q;
		end else if (wakeEvent) begin
			idleMode_q <= 1'b0;
			sleepMode_q <= 1'b0;
		end
	end

	// oscillator enables; the RC osc never stops, it serves the watchdog
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			priOscEn_q <= 1'b1;
			mainOscEn_q <= 1'b0;
			lpRcEn_q <= 1'b1;
		end else begin
			priOscEn_q <= priOscEn_d;
			mainOscEn_q <= mainOscEn_d;
			lpRcEn_q <= 1'b1;
		end
	end

	// clock outputs; sleep pulls the system clock low at once and may
	// cut a high phase, harmless since nothing is clocked in sleep
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sysClk_q <= 1'b0;
			wdtClk_q <= 1'b0;
		end else begin
			sysClk_q <= clkBus.clkOut & !sleepMode_q;
			wdtClk_q <= lpRcOscLvl;
		end
	end

	// switch status and read data, one cycle behind their source
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_q <= 1'b0;
			rdData_q <= 8'h00;
		end else begin
			busy_q <= clkBus.busy;
			rdData_q <= rdData_d;
		end
	end

	assign regRdData = rdData_q;
	assign sysClk = sysClk_q;
	assign priOscEn = priOscEn_q;
	// sleep does not gate the crystal: it may time a real-time clock
	assign secOscEn = secEn_q;
	assign mainIntOscEn = mainOscEn_q;
	assign lpRcOscEn = lpRcEn_q;
	assign mainOscTrim = trim_q;
	assign wdtClk = wdtClk_q;
	assign idleMode = idleMode_q;
	assign sleepMode = sleepMode_q;
	assign switchBusy = busy_q;
endmodule : css_clock_switch

// [test/css_osc_model.sv]
`timescale 1ns/10ps
// oscillators held at their last level while disabled; each toggles slower
// than sys_clk/2 so the design's edge sampling sees every edge
module css_osc_model (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic priOscEn,
	input wire logic secOscEn,
	input wire logic mainIntOscEn,
	input wire logic lpRcOscEn,
	output logic priOscLvl,
	output logic secOscLvl,
	output logic mainIntOscLvl,
	output logic lpRcOscLvl
);
	localparam int HALF[4] = '{2, 3, 2, 5};
	logic [3:0] enVec;
	logic [3:0] lvl_q;
	int cnt_q[4];
	assign enVec = {lpRcOscEn, mainIntOscEn, secOscEn, priOscEn};
	assign {lpRcOscLvl, mainIntOscLvl, secOscLvl, priOscLvl} = lvl_q;
	// secondary runs whenever enabled, so it is settled before selection
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			lvl_q <= 4'h0;
			for (int i = 0; i < 4; i++) cnt_q[i] <= 0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (enVec[i] && cnt_q[i] == HALF[i] - 1) begin
					cnt_q[i] <= 0;
					lvl_q[i] <= ~lvl_q[i];
				end else if (enVec[i]) begin
					cnt_q[i] <= cnt_q[i] + 1;
				end
			end
		end
	end
endmodule : css_osc_model

// [test/css_clock_switch_properties.sv]
`timescale 1ns/10ps
module css_clock_switch_properties import css_pkg::*; #(
	parameter int OST_COUNT = OST_CYCLES,
	parameter int SETTLE_COUNT = SETTLE_EDGES
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regRdData,
	input wire logic sleepExec,
	input wire logic sysClk,
	input wire logic secOscEn,
	input wire logic lpRcOscEn,
	input wire logic lpRcOscLvl,
	input wire logic wdtClk,
	input wire logic idleMode,
	input wire logic sleepMode,
	input wire logic switchBusy
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic idle_q;
	logic sec_q;
	// shadow copies of the writable bits the outputs depend on
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			idle_q <= 1'b0;
			sec_q <= 1'b0;
		end else if (regWrEn && regAddr == OFS_OSC_CTRL) begin
			idle_q <= regWrData[BIT_IDLE];
		end else if (regWrEn && regAddr == OFS_SEC_TMR) begin
			sec_q <= regWrData[BIT_SEC_EN];
		end
	end
	sequence swEnd_s;
		!switchBusy;
	endsequence
	lp_rc_on_a: assert property (lpRcOscEn)
		else $error("low-power rc enable dropped");
	wdt_clk_a: assert property ($past(rst_b) |-> wdtClk == $past(lpRcOscLvl))
		else $error("watchdog clock not from rc osc");
	rd_idle_a: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
		else $error("read data outside read slot");
	sleep_entry_a: assert property (sleepExec |=> idleMode == idle_q && sleepMode == !idle_q)
		else $error("wrong power mode after sleep");
	modes_excl_a: assert property (!(idleMode && sleepMode))
		else $error("idle and sleep together");
	sleep_clk_a: assert property (sleepMode [*4] |-> !sysClk)
		else $error("system clock runs in sleep");
	sec_follow_a: assert property (regWrEn && regAddr == OFS_SEC_TMR |-> ##2 secOscEn == sec_q)
		else $error("secondary enable not following bit");
	busy_bound_a: assert property ($rose(switchBusy) |-> ##[1:600] swEnd_s)
		else $error("clock switch too long");
	flags_excl_a: assert property ($past(regRdEn) && $past(regAddr) == OFS_OSC_CTRL |-> !(regRdData[BIT_PRI_DONE] && regRdData[BIT_INT_STABLE]))
		else $error("two status flags set");
endmodule : css_clock_switch_properties
bind css_clock_switch css_clock_switch_properties #(.OST_COUNT(OST_COUNT),
	.SETTLE_COUNT(SETTLE_COUNT)) chk (.*);

// [test/tb.sv]
`timescale 1ns/10ps
module tb import css_pkg::*;;
	logic sys_clk = 0, rst_b = 0, regWrEn = 0, regRdEn = 0;
	logic [1:0] regAddr = 2'h0;
	logic [7:0] regWrData = 8'h00, regRdData, d;
	logic sleepExec = 0, wakeEvent = 0, sysClk, switchBusy, idleMode;
	logic sleepMode, priOscEn, secOscEn, mainIntOscEn, lpRcOscEn;
	logic priOscLvl, secOscLvl, mainIntOscLvl, lpRcOscLvl;
	logic [4:0] mainOscTrim;
	int n_fail = 0, compares = 0, n;
	always #50 sys_clk = ~sys_clk;
	css_clock_switch #(.OST_COUNT(8), .SETTLE_COUNT(4)) dut (.sys_clk(sys_clk),
		.rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
		.twoSpeedStartupCfg(1'b0), .priOscLvl(priOscLvl),
		.secOscLvl(secOscLvl), .mainIntOscLvl(mainIntOscLvl),
		.lpRcOscLvl(lpRcOscLvl), .sleepExec(sleepExec),
		.wakeEvent(wakeEvent), .sysClk(sysClk), .priOscEn(priOscEn),
		.secOscEn(secOscEn), .mainIntOscEn(mainIntOscEn),
		.lpRcOscEn(lpRcOscEn), .mainOscTrim(mainOscTrim), .wdtClk(),
		.idleMode(idleMode),
		.sleepMode(sleepMode), .switchBusy(switchBusy));
	css_osc_model osc (.sys_clk(sys_clk), .rst_b(rst_b), .priOscEn(priOscEn),
		.secOscEn(secOscEn), .mainIntOscEn(mainIntOscEn),
		.lpRcOscEn(lpRcOscEn), .priOscLvl(priOscLvl), .secOscLvl(secOscLvl),
		.mainIntOscLvl(mainIntOscLvl), .lpRcOscLvl(lpRcOscLvl));
	task stop_test;
		$display("n_fail=%0d compares=%0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= v;
		@(posedge sys_clk);
		regWrEn <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task rd(input logic [1:0] a);
		@(posedge sys_clk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRdEn <= 1'b0;
		#1 d = regRdData;
	endtask : rd
	// bounded wait for a signal level; a hang ends the run
	task wl(input logic v, input logic busy);
		for (int i = 0; i <= 3000; i++) begin
			@(posedge sys_clk);
			#1 if ((busy ? switchBusy : sysClk) === v) return;
		end
		n_fail++;
		$display("unexpected at %0t: wait timed out", $time);
		stop_test();
	endtask : wl
	// time one switch: the first old and new periods are cut by phase,
	// so the pause lies between one old plus two new periods and two
	// old plus four new periods of the model's sources
	task wait_sw(input int lo, input int hi);
		wl(1'b1, 1'b1);
		n = 0;
		while (switchBusy === 1'b1 && n < 3000) begin
			n++;
			@(posedge sys_clk);
			#1;
		end
		chk(16'(n >= lo && n <= hi), 16'h1);
	endtask : wait_sw
	// skip a possibly cut pulse, then count a full high phase
	task meas;
		wl(1'b0, 1'b0);
		wl(1'b1, 1'b0);
		wl(1'b0, 1'b0);
		wl(1'b1, 1'b0);
		n = 0;
		while (sysClk === 1'b1 && n < 3000) begin
			n++;
			@(posedge sys_clk);
			#1;
		end
	endtask : meas
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(OFS_OSC_CTRL);
		chk(d & 8'hF3, 8'h40);
		chk(d & 8'h08, 8'h08);
		rd(2'h3);
		chk(d, 8'h00);
		wr(OFS_OSC_CTRL, 8'h51);
		rd(OFS_OSC_CTRL);
		chk(d & 8'hF3, 8'h50);
		wr(OFS_SEC_TMR, 8'h08);
		wr(OFS_OSC_CTRL, 8'h71);
		wait_sw(16, 32);
		rd(OFS_SEC_TMR);
		chk(d & 8'h48, 8'h48);
		rd(OFS_OSC_CTRL);
		chk(d & 8'h0F, 8'h01);
		wr(OFS_OSC_CTRL, 8'h72);
		wait_sw(14, 28);
		repeat (40) @(posedge sys_clk);
		rd(OFS_OSC_CTRL);
		chk(d & 8'h0F, 8'h06);
		rd(OFS_SEC_TMR);
		chk(d & 8'h40, 8'h00);
		// high phase doubles with each step down of the postscaler
		for (int k = 7; k >= 1; k--) begin
			wr(OFS_OSC_CTRL, {1'b0, 3'(k), 4'h2});
			meas();
			chk(16'(n), (k == 7) ? 16'h2 : 16'(4 << (6 - k)));
		end
		wr(OFS_OSC_TRIM, 8'h95);
		wr(OFS_OSC_CTRL, 8'h02);
		meas();
		chk(16'(n), 16'h200);
		rd(OFS_OSC_TRIM);
		chk({d, 3'h0, mainOscTrim}, 16'h9515);
		wr(OFS_OSC_TRIM, 8'h00);
		meas();
		chk(16'(n), 16'h5);
		chk(16'({priOscEn, mainIntOscEn}), 16'h0);
		rd(OFS_OSC_CTRL);
		chk(d & 8'h0C, 8'h00);
		wr(OFS_OSC_CTRL, 8'hF3);
		meas();
		chk(16'(n), 16'h2);
		for (int s = 1; s >= 0; s--) begin
			wr(OFS_OSC_CTRL, {1'(s), 7'h73});
			@(posedge sys_clk);
			sleepExec <= 1'b1;
			@(posedge sys_clk);
			sleepExec <= 1'b0;
			#1 chk({idleMode, sleepMode}, s ? 16'h2 : 16'h1);
			repeat (8) @(posedge sys_clk);
			wakeEvent <= 1'b1;
			@(posedge sys_clk);
			wakeEvent <= 1'b0;
		end
		wr(OFS_OSC_CTRL, 8'h70);
		wait_sw(12, 24);
		repeat (60) @(posedge sys_clk);
		rd(OFS_OSC_CTRL);
		chk(d & 8'h0C, 8'h08);
		// a reset in the middle of a switch must land on the primary
		wr(OFS_OSC_CTRL, 8'h72);
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(OFS_OSC_CTRL);
		chk(d & 8'hF3, 8'h40);
		chk(16'(switchBusy), 16'h0);
		stop_test();
	end
endmodule : tb
